//--- inc/switch_monitor_map.svh
`ifndef SWITCH_MONITOR_MAP_SVH
`define SWITCH_MONITOR_MAP_SVH

// command word layout, zero-based (printed bit n is index n-1)
`define OPC_HI 15
`define OPC_LO 12
`define PAY_HI 11
`define PAY_LO 0
`define OPC_RUN 4'h1
`define OPC_TRISTATE 4'h3
`define OPC_METALLIC 4'h5

// run payload fields
`define MODE_HI 11
`define MODE_LO 10
`define OFF_HI 9
`define OFF_LO 7
`define WAKE_HI 5
`define WAKE_LO 4
`define POL_HI 3
`define POL_LO 0
`define TIMING_HI 11
`define TIMING_LO 4

// per-input payload split: ground, programmable, battery
`define GND_HI 11
`define GND_LO 6
`define PROG_HI 5
`define PROG_LO 2
`define BATT_HI 1
`define BATT_LO 0

// mode field codes
`define MODE_UNDEF 2'h0
`define MODE_NORMAL 2'h1
`define MODE_POLL 2'h2
`define MODE_POLL_TIMER 2'h3

// off-time multipliers by code
`define OFF_MULT_0 6'h05
`define OFF_MULT_1 6'h09
`define OFF_MULT_2 6'h11
`define OFF_MULT_3 6'h19
`define OFF_MULT_4 6'h21
`define OFF_MULT_5 6'h29
`define OFF_MULT_6 6'h31
`define OFF_MULT_7 6'h39

// wake multipliers by code
`define WAKE_MULT_0 10'h201
`define WAKE_MULT_1 10'h101
`define WAKE_MULT_2 10'h081
`define WAKE_MULT_3 10'h041

// times and clock rate
`define CLK_MHZ 200
`define DETECT_BASE_US 4800
`define ON_TIME_US 5100
`define WAKE_BASE_US 2800

// reset values
`define RUN_RST 12'h000
`define INPUT_EN_RST 12'h000
`define WET_RST 12'h000

// host link timing in clk cycles
`define HOST_HALF_DIV 2
`define HOST_GAP 8

`endif

//--- inc/switch_monitor_pkg.sv
package switch_monitor_pkg;
  typedef enum logic [1:0] {
    mode_sleep,
    mode_normal,
    mode_polling,
    mode_poll_timer
  } op_mode_t;
  typedef enum logic {phase_on, phase_off} poll_phase_t;
  typedef logic [15:0] cmd_word_t;
  typedef logic [11:0] payload_t;
endpackage : switch_monitor_pkg

//--- inc/switch_link_if.sv
`timescale 1ns/10ps
interface switch_link_if;
  import switch_monitor_pkg::*;
  logic link_clk;
  logic cmd_strobe;
  cmd_word_t cmd_word;
  modport dev (input link_clk, input cmd_strobe, input cmd_word);
  modport host (output link_clk, output cmd_strobe, output cmd_word);
endinterface : switch_link_if

//--- logic/switch_monitor_cmd_decoder.sv
// Notes on behaviour
// (R01) run opcode 0001, mode codes select mode
// (R02) polling modes switch input blocks off
// (R03) off time is base times coded multiplier
// (R04) ignore unused timing fields per mode
// (R05) wake interrupt only in timer polling mode
// (R06) wake interval is base times multiplier
// (R07) polarity bit: 0 ground, 1 battery
// (R08) polarity applies in every valid mode
// (R09) tri-state opcode 0011, twelve enable bits
// (R10) enable bit 0 tri-states, 1 enables
// (R11) tri-stated input loses currents, keeps comparator
// (R12) tri-state command keeps operating mode
// (R13) reset clears all input enables
// (R14) metallic opcode 0101, per-input pulse enables
// (R15) metallic command keeps operating mode
// (R16) host writes run and metallic first
// (R17) run field positions in payload
// (R18) other opcodes take no action
// (R19) mode code 00 applies polarity only
// (R20) timing change restarts interval counters
`timescale 1ns/10ps
`include "switch_monitor_map.svh"
module switch_monitor_cmd_decoder
  import switch_monitor_pkg::*;
#(
  parameter int unsigned DETECT_CYC = `DETECT_BASE_US * `CLK_MHZ,
  parameter int unsigned ON_CYC = `ON_TIME_US * `CLK_MHZ,
  parameter int unsigned WAKE_CYC = `WAKE_BASE_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  switch_link_if.dev link,
  output op_mode_t op_mode,
  output logic [2:0] sample_off_sel,
  output logic [1:0] wake_period_sel,
  output logic [3:0] prog_input_polarity,
  output logic [5:0] gnd_input_enable,
  output logic [3:0] prog_input_enable,
  output logic [1:0] batt_input_enable,
  output logic [5:0] gnd_wetting_pulse_en,
  output logic [3:0] prog_wetting_pulse_en,
  output logic [1:0] batt_wetting_pulse_en,
  output logic input_blocks_on,
  output logic [11:0] input_current_on,
  output logic [11:0] wetting_pulse_allowed,
  output logic wake_int_n
);

  if (DETECT_CYC < 1 || ON_CYC < 1 || WAKE_CYC < 1) begin : g_chk_min
    $error("interval counts must be at least one cycle");
  end
  if (64'(DETECT_CYC) * 64'(`OFF_MULT_7) > 64'h0ffff_ffff ||
      64'(WAKE_CYC) * 64'(`WAKE_MULT_0) > 64'h0ffff_ffff) begin : g_chk_max
    $error("interval counts overflow the 32-bit counters");
  end

  function automatic logic [5:0] off_mult_f(input logic [2:0] sel);
    logic [5:0] m;
    m = `OFF_MULT_0;
    unique case (sel)
      3'h0: m = `OFF_MULT_0;
      3'h1: m = `OFF_MULT_1;
      3'h2: m = `OFF_MULT_2;
      3'h3: m = `OFF_MULT_3;
      3'h4: m = `OFF_MULT_4;
      3'h5: m = `OFF_MULT_5;
      3'h6: m = `OFF_MULT_6;
      3'h7: m = `OFF_MULT_7;
    endcase
    return m;
  endfunction : off_mult_f

  function automatic logic [9:0] wake_mult_f(input logic [1:0] sel);
    logic [9:0] m;
    m = `WAKE_MULT_0;
    unique case (sel)
      2'h0: m = `WAKE_MULT_0;
      2'h1: m = `WAKE_MULT_1;
      2'h2: m = `WAKE_MULT_2;
      2'h3: m = `WAKE_MULT_3;
    endcase
    return m;
  endfunction : wake_mult_f

  // link side: capture word, flag it with a toggle
  cmd_word_t lw_reg, lw_next;
  logic tgl_reg, tgl_next;

  always_comb begin
    lw_next = lw_reg;
    tgl_next = tgl_reg;
    if (link.cmd_strobe) begin
      lw_next = link.cmd_word;
      tgl_next = ~tgl_reg;
    end
  end

  always_ff @(posedge link.link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lw_reg <= 16'h0000;
      tgl_reg <= 1'b0;
    end else begin
      lw_reg <= lw_next;
      tgl_reg <= tgl_next;
    end
  end

  // toggle crossing; word is stable long before the edge is seen
  logic sync1_reg, sync2_reg, sync3_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= tgl_reg;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic cmd_evt;
  logic [3:0] opc;
  payload_t pay;
  assign cmd_evt = sync2_reg ^ sync3_reg;
  assign opc = lw_reg[`OPC_HI:`OPC_LO];
  assign pay = lw_reg[`PAY_HI:`PAY_LO];

  // configuration state
  op_mode_t mode_reg, mode_next;
  payload_t run_reg, run_next;
  payload_t en_reg, en_next;
  payload_t wet_reg, wet_next;
  logic restart;

  always_comb begin
    mode_next = mode_reg;
    run_next = run_reg;
    en_next = en_reg;
    wet_next = wet_reg;
    restart = 1'b0;
    if (cmd_evt) begin
      unique case (opc)
        // (R01) run decode
        `OPC_RUN: begin
          // (R19) undefined mode keeps all but polarity
          if (pay[`MODE_HI:`MODE_LO] == `MODE_UNDEF) begin
            run_next = {run_reg[`TIMING_HI:`TIMING_LO],
                        pay[`POL_HI:`POL_LO]};
          end else begin
            // (R17) field positions kept as received
            run_next = pay;
            unique case (pay[`MODE_HI:`MODE_LO])
              `MODE_NORMAL: mode_next = mode_normal;
              `MODE_POLL: mode_next = mode_polling;
              default: mode_next = mode_poll_timer;
            endcase
          end
          // (R20) restart on timing change
          restart = (mode_next != mode_reg) ||
            (run_next[`TIMING_HI:`TIMING_LO] !=
             run_reg[`TIMING_HI:`TIMING_LO]);
        end
        // (R09) (R12) enables only, mode untouched
        `OPC_TRISTATE: en_next = pay;
        // (R14) (R15) pulse enables only, mode untouched
        `OPC_METALLIC: wet_next = pay;
        // (R18) other opcodes ignored
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= mode_sleep;
      // (R13) (R16) inputs tri-stated, configs cleared
      run_reg <= `RUN_RST;
      en_reg <= `INPUT_EN_RST;
      wet_reg <= `WET_RST;
    end else if (ce) begin
      mode_reg <= mode_next;
      run_reg <= run_next;
      en_reg <= en_next;
      wet_reg <= wet_next;
    end
  end

  // interval timers
  poll_phase_t phase_reg, phase_next;
  logic [31:0] poll_cnt_reg, poll_cnt_next;
  logic [31:0] wake_cnt_reg, wake_cnt_next;
  logic [31:0] off_limit, wake_limit, poll_limit;
  logic polling, wake_hit;

  // (R03) off time scaled from base period
  assign off_limit = 32'(off_mult_f(run_reg[`OFF_HI:`OFF_LO])) *
    32'(DETECT_CYC);
  // (R06) wake interval scaled from base period
  assign wake_limit = 32'(wake_mult_f(run_reg[`WAKE_HI:`WAKE_LO])) *
    32'(WAKE_CYC);
  assign poll_limit = (phase_reg == phase_on) ? 32'(ON_CYC) : off_limit;
  // (R04) off field matters only while polling
  assign polling = (mode_reg == mode_polling) ||
    (mode_reg == mode_poll_timer);

  always_comb begin
    phase_next = phase_reg;
    poll_cnt_next = poll_cnt_reg + 32'h1;
    wake_cnt_next = wake_cnt_reg + 32'h1;
    wake_hit = 1'b0;
    if (restart || !polling) begin
      phase_next = phase_on;
      poll_cnt_next = 32'h0;
    end else if (poll_cnt_reg >= poll_limit - 32'h1) begin
      poll_cnt_next = 32'h0;
      phase_next = (phase_reg == phase_on) ? phase_off : phase_on;
    end
    // (R04) wake field counts only in timer mode
    if (restart || mode_reg != mode_poll_timer) begin
      wake_cnt_next = 32'h0;
    end else if (wake_cnt_reg >= wake_limit - 32'h1) begin
      wake_cnt_next = 32'h0;
      // (R05) periodic wake interrupt
      wake_hit = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= phase_on;
      poll_cnt_reg <= 32'h0;
      wake_cnt_reg <= 32'h0;
    end else if (ce) begin
      phase_reg <= phase_next;
      poll_cnt_reg <= poll_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // registered drive to the analog side
  logic blocks_reg, blocks_next;
  payload_t cur_reg, cur_next;
  payload_t wp_reg, wp_next;
  logic int_n_reg, int_n_next;

  always_comb begin
    // (R02) blocks dark during the off phase
    blocks_next = (mode_reg == mode_normal) ||
      (polling && phase_reg == phase_on);
    // (R10) (R11) currents only for enabled inputs
    cur_next = blocks_next ? en_reg : 12'h000;
    wp_next = cur_next & wet_reg;
    int_n_next = ~wake_hit;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blocks_reg <= 1'b0;
      cur_reg <= 12'h000;
      wp_reg <= 12'h000;
      int_n_reg <= 1'b1;
    end else if (ce) begin
      blocks_reg <= blocks_next;
      cur_reg <= cur_next;
      wp_reg <= wp_next;
      int_n_reg <= int_n_next;
    end
  end

  assign op_mode = mode_reg;
  assign sample_off_sel = run_reg[`OFF_HI:`OFF_LO];
  assign wake_period_sel = run_reg[`WAKE_HI:`WAKE_LO];
  // (R07) (R08) polarity straight from the run payload
  assign prog_input_polarity = run_reg[`POL_HI:`POL_LO];
  assign gnd_input_enable = en_reg[`GND_HI:`GND_LO];
  assign prog_input_enable = en_reg[`PROG_HI:`PROG_LO];
  assign batt_input_enable = en_reg[`BATT_HI:`BATT_LO];
  assign gnd_wetting_pulse_en = wet_reg[`GND_HI:`GND_LO];
  assign prog_wetting_pulse_en = wet_reg[`PROG_HI:`PROG_LO];
  assign batt_wetting_pulse_en = wet_reg[`BATT_HI:`BATT_LO];
  assign input_blocks_on = blocks_reg;
  assign input_current_on = cur_reg;
  assign wetting_pulse_allowed = wp_reg;
  assign wake_int_n = int_n_reg;

endmodule : switch_monitor_cmd_decoder

//--- logic/switch_monitor_host.sv
`timescale 1ns/10ps
`include "switch_monitor_map.svh"
module switch_monitor_host
  import switch_monitor_pkg::*;
#(
  parameter int unsigned HALF_DIV = `HOST_HALF_DIV,
  parameter int unsigned GAP = `HOST_GAP
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  switch_link_if.host link,
  input wire logic cmd_valid,
  input wire cmd_word_t cmd_word,
  output logic cmd_ready
);

  if (HALF_DIV < 1 || HALF_DIV > 255 || GAP < 4 || GAP > 255)
  begin : g_chk
    $error("divider or gap out of range");
  end

  typedef enum logic [1:0] {st_idle, st_low, st_high, st_gap} host_st_t;

  host_st_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next;
  logic lclk_reg, lclk_next;
  logic stb_reg, stb_next;
  cmd_word_t word_reg, word_next;

  // link clock runs only inside a frame: one rising edge per word
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 8'h1;
    lclk_next = lclk_reg;
    stb_next = stb_reg;
    word_next = word_reg;
    unique case (st_reg)
      st_idle: begin
        cnt_next = 8'h0;
        if (cmd_valid) begin
          // (R01) (R09) (R14) word sent as given
          word_next = cmd_word;
          stb_next = 1'b1;
          st_next = st_low;
        end
      end
      st_low: if (cnt_reg == 8'(HALF_DIV - 1)) begin
        cnt_next = 8'h0;
        lclk_next = 1'b1;
        st_next = st_high;
      end
      st_high: if (cnt_reg == 8'(HALF_DIV - 1)) begin
        cnt_next = 8'h0;
        lclk_next = 1'b0;
        stb_next = 1'b0;
        st_next = st_gap;
      end
      // gap lets the device cross the word before the next one
      st_gap: if (cnt_reg == 8'(GAP - 1)) begin
        st_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= st_idle;
      cnt_reg <= 8'h0;
      lclk_reg <= 1'b0;
      stb_reg <= 1'b0;
      word_reg <= 16'h0000;
    end else if (ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      lclk_reg <= lclk_next;
      stb_reg <= stb_next;
      word_reg <= word_next;
    end
  end

  assign cmd_ready = (st_reg == st_idle);
  assign link.link_clk = lclk_reg;
  assign link.cmd_strobe = stb_reg;
  assign link.cmd_word = word_reg;

endmodule : switch_monitor_host

//--- testbench/switch_link_assertions.sv
`timescale 1ns/10ps
module switch_link_assertions
  import switch_monitor_pkg::*;
#(
  parameter int unsigned HALF_DIV = 2,
  parameter int unsigned GAP = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic cmd_strobe,
  input wire cmd_word_t cmd_word
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // saturate so the first frame after reset sees a long gap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'hff;
    end else begin
      hi_cnt <= link_clk ? hi_cnt + 8'h01 : 8'h00;
      if (cmd_strobe) lo_cnt <= 8'h00;
      else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
    end
  end
  AST_CLK_IN_FRAME: assert property (link_clk |-> cmd_strobe)
    else $error("link clock high outside frame");
  AST_WORD_STABLE: assert property (cmd_strobe && $past(cmd_strobe)
    |-> $stable(cmd_word))
    else $error("command word moved in frame");
  AST_EDGE_FOLLOWS: assert property ($rose(cmd_strobe)
    |-> !link_clk ##[1:16] link_clk)
    else $error("no link clock edge in frame");
  AST_HIGH_LEN: assert property ($fell(link_clk)
    |-> hi_cnt == 8'(HALF_DIV))
    else $error("link clock high time wrong");
  AST_FRAME_END: assert property ($fell(link_clk) |-> $fell(cmd_strobe))
    else $error("strobe not ended with clock");
  AST_ONE_EDGE: assert property ($fell(link_clk) |-> (!link_clk)[*8])
    else $error("second link clock edge");
  AST_GAP: assert property ($rose(cmd_strobe) |-> lo_cnt > 8'(GAP))
    else $error("frame gap too short");
  AST_SAMPLE_EDGE: assert property ($rose(link_clk)
    |-> cmd_strobe && $stable(cmd_word))
    else $error("word unsettled at link edge");
endmodule : switch_link_assertions

//--- testbench/tb_switch_monitor_cmd_decoder.sv
`timescale 1ns/10ps
module tb_switch_monitor_cmd_decoder;
  import switch_monitor_pkg::*;
  localparam int DET = 4;
  localparam int WK = 3;
  logic clk, sys_rst, ce, cmd_valid, cmd_ready, blk_on, wake_n;
  logic rdy_q = 1'b1;
  cmd_word_t cmd_word;
  op_mode_t op_mode;
  logic [2:0] off;
  logic [1:0] wk, be, bw;
  logic [3:0] pol, pe, pw;
  logic [5:0] ge, gw;
  logic [11:0] cur_on, wet_ok;
  logic [34:0] got, e, g, exp_s;
  logic [60:0] frz;
  logic [34:0] q_c[$];
  int q_t[$], q_w[$];
  int n_fail, check_count, lo_len, wk_cnt, i;
  bit wk_seen;
  int off_mult[8] = '{5, 9, 17, 25, 33, 41, 49, 57};
  int wake_mult[4] = '{513, 257, 129, 65};
  assign got = {op_mode, off, wk, pol, ge, pe, be, gw, pw, bw};
  switch_link_if link_i();
  switch_monitor_host u_switch_monitor_host (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .link(link_i), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready));
  switch_monitor_cmd_decoder #(.DETECT_CYC(DET), .ON_CYC(6), .WAKE_CYC(WK))
    u_switch_monitor_cmd_decoder (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .link(link_i), .op_mode(op_mode), .sample_off_sel(off),
    .wake_period_sel(wk), .prog_input_polarity(pol),
    .gnd_input_enable(ge), .prog_input_enable(pe), .batt_input_enable(be),
    .gnd_wetting_pulse_en(gw), .prog_wetting_pulse_en(pw),
    .batt_wetting_pulse_en(bw), .input_blocks_on(blk_on),
    .input_current_on(cur_on), .wetting_pulse_allowed(wet_ok),
    .wake_int_n(wake_n));
  switch_link_assertions u_switch_link_assertions (.clk(clk),
    .sys_rst(sys_rst), .link_clk(link_i.link_clk),
    .cmd_strobe(link_i.cmd_strobe), .cmd_word(link_i.cmd_word));

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task give_up(input string msg);
    chk(1'b0, msg);
    report_and_stop;
  endtask : give_up

  // expected register state kept from the command codes
  task send(input cmd_word_t w);
    case (w[15:12])
      4'h1: begin
        if (w[11:10] != 2'h0) exp_s[34:28] = {w[11:7], w[5:4]};
        exp_s[27:24] = w[3:0];
      end
      4'h3: exp_s[23:12] = w[11:0];
      4'h5: exp_s[11:0] = w[11:0];
      default: ;
    endcase
    q_c.push_back(exp_s);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(posedge clk);
    if (i == 40) give_up("ready lost");
  endtask : send

  task wait_empty;
    for (i = 0; i < 5000 && q_t.size() + q_w.size() > 0; i++) @(posedge clk);
    if (i == 5000) give_up("timer never seen");
  endtask : wait_empty

  // fields ignored by the current mode are masked out
  // sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clk) begin
    if (cmd_ready === 1'b1 && rdy_q === 1'b0 && q_c.size() > 0) begin
      e = q_c.pop_front();
      g = got;
      if (!e[34]) {e[32:30], g[32:30]} = 6'h00;
      if (e[34:33] != 2'h3) {e[29:28], g[29:28]} = 4'h0;
      chk(g === e, "config");
      if (e[34:33] == 2'h1)
        chk(cur_on === e[23:12] && wet_ok === (e[23:12] & e[11:0])
          && blk_on === 1'b1, "currents");
    end
    rdy_q = cmd_ready;
    if (blk_on === 1'b0) begin
      if (lo_len > 1) chk(cur_on === 12'h000, "off current");
      lo_len++;
    end else begin
      if (lo_len > 0 && q_t.size() > 0)
        chk(lo_len == q_t.pop_front(), "off time");
      lo_len = 0;
    end
    if (wake_n === 1'b0) begin
      chk(op_mode === mode_poll_timer, "stray wake");
      if (wk_seen) chk(wk_cnt == q_w.pop_front(), "wake period");
      wk_seen = q_w.size() > 0;
      wk_cnt = 1;
    end else wk_cnt++;
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {sys_rst, ce, cmd_valid, cmd_word} = {1'b1, 1'b1, 1'b0, 16'h0000};
    {n_fail, check_count, lo_len, wk_cnt, wk_seen} = 0;
    exp_s = 35'h0;
    void'($urandom(88713));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(got === 35'h0 && wake_n === 1'b1 && blk_on === 1'b0, "reset");
    send({4'h3, 12'($urandom)});
    send({4'h5, 12'($urandom)});
    send({4'h1, 2'h1, 10'($urandom)});
    send({4'h5, 12'($urandom)});
    $display("test commands done");
    for (int k = 0; k < 16; k++)
      if (!(k inside {1, 3, 5})) send({4'(k), 12'($urandom)});
    send({4'h1, 2'h0, 10'($urandom)});
    $display("test opcodes done");
    for (int k = 0; k < 8; k++) begin
      send({4'h1, 2'h2, 3'(k), 1'b0, 2'($urandom), 4'($urandom)});
      q_t.push_back(off_mult[k] * DET);
      wait_empty;
    end
    send({4'h3, 12'($urandom)});
    $display("test polling done");
    for (int k = 0; k < 4; k++) begin
      send({4'h1, 2'h3, 3'($urandom), 1'b0, 2'(k), 4'($urandom)});
      q_w.push_back(wake_mult[k] * WK);
      wait_empty;
    end
    send({4'h5, 12'($urandom)});
    $display("test wake done");
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    frz = {got, cur_on, wet_ok, blk_on, wake_n};
    repeat (300) @(posedge clk);
    chk(frz === {got, cur_on, wet_ok, blk_on, wake_n}, "freeze");
    ce <= 1'b1;
    $display("test freeze done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    exp_s = 35'h0;
    @(posedge clk);
    chk(got === 35'h0 && cur_on === 12'h000, "second reset");
    send({4'h1, 2'h1, 10'($urandom)});
    repeat (2) @(posedge clk);
    $display("test reset done");
    report_and_stop;
  end
endmodule : tb_switch_monitor_cmd_decoder
